// ### core/axis_corrector.sv
// gain and offset correction of the three axis samples ahead of the angle engine
// assumes samples are signed 16-bit words at full scale, one valid pulse per set
`include "sensor_cal_defines.svh"
module axis_corrector (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [1:0] gain_sel_in,
	input wire logic [10:0] gain_val_in,
	input wire logic [1:0] off_sel_in,
	input wire logic [6:0] off1_in,
	input wire logic [6:0] off2_in,
	input wire logic [1:0] angle_pair_in,
	input wire logic sample_valid_in,
	input wire logic [15:0] x_in,
	input wire logic [15:0] y_in,
	input wire logic [15:0] z_in,
	output logic [15:0] x_out,
	output logic [15:0] y_out,
	output logic [15:0] z_out,
	output logic valid_out
);
	// does an offset word land on this axis for the given selection and pair
	function automatic logic off_hits(input logic [1:0] axis, input logic first,
		input logic [1:0] sel, input logic [1:0] pair);
		logic [1:0] target;
		target = first ? ((pair == 2'h2) ? 2'h2 : 2'h1) : ((pair == 2'h1) ? 2'h2 : 2'h3);
		return (pair != 2'h0) && (first ? sel[0] : sel[1]) && (target == axis);
	endfunction
	logic [15:0] samp [3];
	logic [15:0] corr_reg [3];
	logic valid_reg;
	logic [15:0] off1_term;
	logic [15:0] off2_term;
	assign samp[0] = x_in;
	assign samp[1] = y_in;
	assign samp[2] = z_in;
	// offset words as low bits of an 11-bit field, lifted to full scale
	assign off1_term = {{4{off1_in[6]}}, off1_in, 5'h00};
	assign off2_term = {{4{off2_in[6]}}, off2_in, 5'h00};
	genvar i;
	generate
		for (i = 0; i < 3; i++)
		begin : g_axis
			localparam logic [1:0] CODE = 2'(i + 1);
			logic signed [27:0] prod;
			logic [15:0] gained;
			logic [15:0] sum;
			// gain as value over 1024, only on the chosen axis
			assign prod = $signed(samp[i]) * $signed({1'b0, gain_val_in});
			assign gained = (gain_sel_in == CODE) ? prod[25:10] : samp[i];
			// offsets that apply to this axis, at most one of the two words on any one axis
			assign sum = gained + (off_hits(CODE, 1'b1, off_sel_in, angle_pair_in) ? off1_term
				: 16'h0000) + (off_hits(CODE, 1'b0, off_sel_in, angle_pair_in) ? off2_term
				: 16'h0000);
			always_ff @(posedge clk_in or negedge rstn_in)
			begin
				if (!rstn_in)
					corr_reg[i] <= `WORD_RESET;
				else if (sample_valid_in)
					corr_reg[i] <= sum;
			end
		end
	endgenerate
	// one-cycle valid behind each corrected set
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			valid_reg <= 1'b0;
		else
			valid_reg <= sample_valid_in;
	end
	assign x_out = corr_reg[0];
	assign y_out = corr_reg[1];
	assign z_out = corr_reg[2];
	assign valid_out = valid_reg;
	a_no_corr_pass: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(sample_valid_in && gain_sel_in == 2'h0 && off_sel_in == 2'h0)
		|=> (x_out == $past(x_in) && y_out == $past(y_in) && z_out == $past(z_in)))
		else $error("uncorrected sample changed");
	a_pair_none_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(sample_valid_in && gain_sel_in == 2'h0 && angle_pair_in == 2'h0)
		|=> (x_out == $past(x_in) && z_out == $past(z_in)))
		else $error("offset applied with no axis pair");
endmodule

// ### core/osc_cycle_counter.sv
// 16-bit tally of fast or slow oscillator cycles
// assumes oscillator levels arrive synchronous to clk_in and no faster than half its rate
`include "sensor_cal_defines.svh"
module osc_cycle_counter (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire sensor_cal_pkg::osc_ctl_e ctl_in,
	input wire logic fast_osc_in,
	input wire logic slow_osc_in,
	output logic [15:0] tally_out
);
	logic fast_prev_reg;
	logic slow_prev_reg;
	logic [15:0] tally_reg;
	logic [15:0] tally_next;
	logic tick;
	// rising edge of the chosen oscillator
	assign tick = ((ctl_in == sensor_cal_pkg::OSC_RUN_FAST) && fast_osc_in && !fast_prev_reg)
		|| ((ctl_in == sensor_cal_pkg::OSC_RUN_SLOW) && slow_osc_in && !slow_prev_reg);
	// clear, count with plain wrap, or hold
	assign tally_next = (ctl_in == sensor_cal_pkg::OSC_CLEAR) ? `WORD_RESET :
		(tick ? tally_reg + 16'h0001 : tally_reg);
	assign tally_out = tally_reg;
	// edge history and tally
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			fast_prev_reg <= 1'b0;
			slow_prev_reg <= 1'b0;
			tally_reg <= `WORD_RESET;
		end
		else
		begin
			fast_prev_reg <= fast_osc_in;
			slow_prev_reg <= slow_osc_in;
			tally_reg <= tally_next;
		end
	end
	a_tally_wraps: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(tick && tally_reg == 16'hffff) |=> (tally_reg == 16'h0000))
		else $error("tally did not wrap to zero");
	a_tally_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ctl_in == sensor_cal_pkg::OSC_CLEAR) |=> (tally_reg == 16'h0000))
		else $error("tally not cleared");
	a_tally_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(ctl_in == sensor_cal_pkg::OSC_HOLD) |=> $stable(tally_reg))
		else $error("tally moved while stopped");
endmodule

// ### core/sensor_cal_defines.svh
// register offsets, field positions, reset values and scaling constants
// assumes inclusion by bare name from every core file that needs them
`ifndef SENSOR_CAL_DEFINES_SVH
`define SENSOR_CAL_DEFINES_SVH
// register word offsets
`define TEST_SETUP_ADDR 8'h0f
`define OSC_MON_ADDR 8'h10
`define GAIN_CORR_ADDR 8'h11
`define OFFSET_CORR_ADDR 8'h12
`define ANGLE_OUT_ADDR 8'h13
`define VECTOR_LEN_ADDR 8'h14
// test setup fields
`define CTL_LSB 0
`define CHK_OFF_BIT 2
`define TEST_RSVD3_BIT 3
`define REV_LSB 4
`define TEST_RSVD_LSB 6
`define TEST_RSVD_VAL 10'h001
// gain and offset fields
`define SEL_LSB 14
`define GAIN_RSVD_LSB 11
`define OFF1_LSB 7
`define OFF2_LSB 0
`define GAIN_FRAC_BITS 10
`define OFF_SCALE_SHIFT 5
// result fields
`define ANGLE_BITS 13
// reset values
`define WORD_RESET 16'h0000
`define SEL_RESET 2'h0
`define GAIN_RESET 11'h000
`define OFF_RESET 7'h00
`define ANGLE_RESET 13'h0000
// arbitrary revision code, not tied to any product
`define SILICON_REV_DEFAULT 2'h3
`endif

// ### core/sensor_cal_pkg.sv
// shared types of the calibration and test register bank
// assumes nothing of its surroundings
package sensor_cal_pkg;
	typedef enum logic [1:0] {
		OSC_CLEAR = 2'h0,
		OSC_RUN_FAST = 2'h1,
		OSC_RUN_SLOW = 2'h2,
		OSC_HOLD = 2'h3
	} osc_ctl_e;
	typedef enum logic [1:0] {
		AXIS_NONE = 2'h0,
		AXIS_X = 2'h1,
		AXIS_Y = 2'h2,
		AXIS_Z = 2'h3
	} axis_sel_e;
	typedef logic [15:0] reg_word_t;
endpackage

// ### core/sensor_cal_test_regs.sv
// calibration and test register bank of the hall position sensor
// assumes the serial front end presents decoded word accesses on the register port,
// and that results and oscillator levels are synchronous to clk_in
//
// Notes on behaviour
// - test setup bit 2, reset 0: 0 keeps checksums, 1 switches them off.
// - test setup bits 5-4 read a fixed revision code; writes leave it.
// - counter control: 0 clears, 1 counts fast, 2 counts slow, 3 stops.
// - cycle tally register returns counted cycles in bits 15-0.
// - the 16-bit tally wraps to zero at its maximum and keeps counting.
// - gain bits 15-14 pick the corrected axis: none, x, y or z.
// - gain bits 10-0 scale the chosen axis by value over 1024.
// - offset selection 01b applies only the first word, by axis pair.
// - offset selection 10b applies only the second word, by axis pair.
// - selection 11b applies both words; pair 00b or selection 00b applies none.
// - offset words sit at bits 13-7 and 6-0, signed, reset zero.
// - each offset word is the low seven bits of an 11-bit full-scale value.
// - angle register: 13 low bits, four fraction bits in sixteenths.
// - gain and offset selections read zero after reset.
// - vector length register returns the computed magnitude, reset zero.
`include "sensor_cal_defines.svh"
module sensor_cal_test_regs #(
	parameter logic [1:0] SILICON_REV = `SILICON_REV_DEFAULT
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic reg_err_out,
	input wire logic fast_osc_in,
	input wire logic slow_osc_in,
	input wire logic [1:0] angle_pair_in,
	input wire logic sample_valid_in,
	input wire logic [15:0] x_in,
	input wire logic [15:0] y_in,
	input wire logic [15:0] z_in,
	input wire logic result_valid_in,
	input wire logic [12:0] angle_in,
	input wire logic [15:0] magnitude_in,
	output logic checksum_off_out,
	output logic [15:0] x_corr_out,
	output logic [15:0] y_corr_out,
	output logic [15:0] z_corr_out,
	output logic corr_valid_out
);
	// software-written state
	logic checksum_off_reg;
	sensor_cal_pkg::osc_ctl_e osc_ctl_reg;
	logic [1:0] gain_sel_reg;
	logic [10:0] gain_val_reg;
	logic [1:0] off_sel_reg;
	logic [6:0] off1_reg;
	logic [6:0] off2_reg;
	// captured results
	logic [12:0] angle_reg;
	logic [15:0] vector_len_reg;
	// read return
	logic [15:0] rdata_reg;
	logic rvalid_reg;
	logic err_reg;
	logic [15:0] rdata_next;
	logic err_next;
	logic [15:0] osc_cycle_tally;

	// address decode
	logic hit_test;
	logic hit_osc;
	logic hit_gain;
	logic hit_off;
	logic hit_angle;
	logic hit_len;
	logic mapped;
	assign hit_test = (reg_addr_in == `TEST_SETUP_ADDR);
	assign hit_osc = (reg_addr_in == `OSC_MON_ADDR);
	assign hit_gain = (reg_addr_in == `GAIN_CORR_ADDR);
	assign hit_off = (reg_addr_in == `OFFSET_CORR_ADDR);
	assign hit_angle = (reg_addr_in == `ANGLE_OUT_ADDR);
	assign hit_len = (reg_addr_in == `VECTOR_LEN_ADDR);
	assign mapped = hit_test || hit_osc || hit_gain || hit_off || hit_angle || hit_len;

	// write strobes, only writable registers take them
	logic wr_test;
	logic wr_gain;
	logic wr_off;
	assign wr_test = reg_wr_in && hit_test;
	assign wr_gain = reg_wr_in && hit_gain;
	assign wr_off = reg_wr_in && hit_off;

	// read views of each register, reserved bits fixed
	logic [15:0] test_view;
	logic [15:0] gain_view;
	logic [15:0] off_view;
	logic [15:0] angle_view;
	assign test_view = {`TEST_RSVD_VAL, SILICON_REV, 1'b0,
		checksum_off_reg, osc_ctl_reg};
	assign gain_view = {gain_sel_reg, 3'h0, gain_val_reg};
	assign off_view = {off_sel_reg, off1_reg, off2_reg};
	assign angle_view = {3'h0, angle_reg};

	// read data select, zero for an unmapped word
	assign rdata_next = hit_test ? test_view :
		hit_osc ? osc_cycle_tally :
		hit_gain ? gain_view :
		hit_off ? off_view :
		hit_angle ? angle_view :
		hit_len ? vector_len_reg :
		`WORD_RESET;
	assign err_next = (reg_rd_in || reg_wr_in) && !mapped;

	// test setup register, revision and reserved bits are not stored
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			checksum_off_reg <= 1'b0;
			osc_ctl_reg <= sensor_cal_pkg::OSC_CLEAR;
		end
		else if (wr_test)
		begin
			checksum_off_reg <= reg_wdata_in[`CHK_OFF_BIT];
			osc_ctl_reg <= sensor_cal_pkg::osc_ctl_e'(reg_wdata_in[`CTL_LSB +: 2]);
		end
	end

	// gain correction register
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			gain_sel_reg <= `SEL_RESET;
			gain_val_reg <= `GAIN_RESET;
		end
		else if (wr_gain)
		begin
			gain_sel_reg <= reg_wdata_in[`SEL_LSB +: 2];
			gain_val_reg <= reg_wdata_in[10:0];
		end
	end

	// offset correction register
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			off_sel_reg <= `SEL_RESET;
			off1_reg <= `OFF_RESET;
			off2_reg <= `OFF_RESET;
		end
		else if (wr_off)
		begin
			off_sel_reg <= reg_wdata_in[`SEL_LSB +: 2];
			off1_reg <= reg_wdata_in[`OFF1_LSB +: 7];
			off2_reg <= reg_wdata_in[`OFF2_LSB +: 7];
		end
	end

	// angle and magnitude results held until the next measurement
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			angle_reg <= `ANGLE_RESET;
			vector_len_reg <= `WORD_RESET;
		end
		else if (result_valid_in)
		begin
			angle_reg <= angle_in;
			vector_len_reg <= magnitude_in;
		end
	end

	// read return one cycle after the request
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rdata_reg <= `WORD_RESET;
			rvalid_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= reg_rd_in ? rdata_next : rdata_reg;
			rvalid_reg <= reg_rd_in;
			err_reg <= err_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;
	assign reg_err_out = err_reg;
	assign checksum_off_out = checksum_off_reg;

	// oscillator cycle counter
	osc_cycle_counter u_osc_counter (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ctl_in(osc_ctl_reg),
		.fast_osc_in(fast_osc_in),
		.slow_osc_in(slow_osc_in),
		.tally_out(osc_cycle_tally)
	);

	// axis gain and offset correction
	axis_corrector u_corrector (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.gain_sel_in(gain_sel_reg),
		.gain_val_in(gain_val_reg),
		.off_sel_in(off_sel_reg),
		.off1_in(off1_reg),
		.off2_in(off2_reg),
		.angle_pair_in(angle_pair_in),
		.sample_valid_in(sample_valid_in),
		.x_in(x_in),
		.y_in(y_in),
		.z_in(z_in),
		.x_out(x_corr_out),
		.y_out(y_corr_out),
		.z_out(z_corr_out),
		.valid_out(corr_valid_out)
	);

	// checks on the register port
	a_checksum_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
		wr_test |=> (checksum_off_out == $past(reg_wdata_in[`CHK_OFF_BIT])))
		else $error("checksum switch did not follow write");

	a_rev_fixed: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(reg_rd_in && hit_test) |=> (reg_rdata_out[5:4] == SILICON_REV))
		else $error("revision code wrong");

	a_test_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(reg_rd_in && hit_test) |=> (reg_rdata_out[15:6] == 10'h001 && !reg_rdata_out[3]))
		else $error("test setup reserved bits wrong");

	a_gain_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(reg_rd_in && hit_gain) |=> (reg_rdata_out[13:11] == 3'h0))
		else $error("gain reserved bits not zero");

	a_tally_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(reg_rd_in && hit_osc) |=> (reg_rdata_out == $past(osc_cycle_tally)))
		else $error("tally read mismatch");

	a_angle_upper: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(result_valid_in ##1 (reg_rd_in && hit_angle && !result_valid_in))
		|=> (reg_rdata_out == {3'h0, $past(angle_in, 2)}))
		else $error("angle read wrong");

	a_len_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
		result_valid_in |=> (vector_len_reg == $past(magnitude_in)))
		else $error("vector length not captured");

	a_off_roundtrip: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(wr_off ##1 (reg_rd_in && hit_off && !reg_wr_in))
		|=> (reg_rdata_out == $past(reg_wdata_in, 2)))
		else $error("offset register did not read back");

	a_ctl_drives: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(wr_test && reg_wdata_in[1:0] == 2'h0) ##1 !wr_test
		|=> (osc_cycle_tally == 16'h0000))
		else $error("counter not cleared by control code");

	a_unmapped: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(reg_rd_in && !mapped) |=> (reg_err_out && reg_rvalid_out && reg_rdata_out == 16'h0000))
		else $error("unmapped read not flagged");

	a_sel_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(rstn_in) |-> (gain_sel_reg == 2'h0 && off_sel_reg == 2'h0))
		else $error("selections not zero after reset");
endmodule

// ### verif/reg_host_model.sv
// register port host standing in for the serial master of the sensor
// assumes the bank's clock; requests move 1 ns after the rising edge
module reg_host_model (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	input wire logic err_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// drop strobes after the taking edge; released lines show inverted values
	task automatic release_bus();
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = ~addr_out;
		wdata_out = ~wdata_out;
	endtask
	// one write strobe, no acknowledge expected
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		release_bus();
	endtask
	// one read strobe; answer awaited a bounded number of cycles
	task automatic read(input logic [7:0] a, output logic [15:0] d, output logic e,
		output logic ok);
		ok = 1'b0;
		d = 16'h0000;
		e = 1'b0;
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		release_bus();
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (rvalid_in === 1'b1)
			begin
				d = rdata_in;
				e = err_in;
				ok = 1'b1;
			end
			else
			begin
				@(posedge clk_in);
				#1;
			end
		end
	endtask
endmodule

// ### verif/sensor_cal_test_regs_tb_top.sv
// self-checking bench of the calibration and test register bank
// assumes the host model owns the register port; the bench drives the rest
module sensor_cal_test_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] REV = 2'h2; // arbitrary revision code
	localparam logic [15:0] TS = 16'h0040 | {10'h000, REV, 4'h0};
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, xs, ys, zs, xc, yc, zc, mag, gw, ow;
	logic wr, rd, rvalid, err, fosc, sosc, sval, rval, chk_off, cval;
	logic [1:0] pair;
	logic [12:0] ang;
	logic [31:0] seed = 32'h7;
	logic [31:0] r;
	int bad_count = 0;
	int cmp_count = 0;
	int n;
	always #25 clk_in = ~clk_in;
	sensor_cal_test_regs #(.SILICON_REV(REV)) i_sensor_cal_test_regs (
		.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.reg_err_out(err), .fast_osc_in(fosc), .slow_osc_in(sosc), .angle_pair_in(pair),
		.sample_valid_in(sval), .x_in(xs), .y_in(ys), .z_in(zs), .result_valid_in(rval),
		.angle_in(ang), .magnitude_in(mag), .checksum_off_out(chk_off), .x_corr_out(xc),
		.y_corr_out(yc), .z_corr_out(zc), .corr_valid_out(cval)
	);
	reg_host_model i_reg_host_model (
		.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
		.rdata_in(rdata), .rvalid_in(rvalid), .err_in(err)
	);
	// xorshift source, seeded with 7
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// reference correction: gain over 1024, offsets as 7-bit words shifted by 5
	function automatic logic [15:0] corr(input logic [15:0] s, input bit g, input bit o1,
		input bit o2, input logic [10:0] gv, input logic [6:0] w1, input logic [6:0] w2);
		int v;
		v = $signed(s);
		if (g)
			v = (v * int'(gv)) >>> 10;
		if (o1)
			v += $signed(w1) * 32;
		if (o2)
			v += $signed(w2) * 32;
		return v[15:0];
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk16(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		i_reg_host_model.write(a, d);
	endtask
	// read a word and compare data and error flag; a lost answer ends the run
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e,
		input logic ee);
		logic [15:0] d;
		logic er;
		logic ok;
		i_reg_host_model.read(a, d, er, ok);
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("[FAIL] %s expected answer seen none", nm);
			summarize();
		end
		chk16(nm, e, d);
		chk1({nm, "_err"}, ee, er);
	endtask
	// pulse each oscillator a given number of times, one rising edge per two cycles
	task automatic pulses(input int nf, input int ns);
		for (int i = 0; i < nf || i < ns; i++)
		begin
			fosc = (i < nf);
			sosc = (i < ns);
			@(posedge clk_in);
			#1;
			fosc = 1'b0;
			sosc = 1'b0;
			@(posedge clk_in);
			#1;
		end
	endtask
	// main sequence
	initial
	begin
		{fosc, sosc, sval, rval, pair, ang, mag, xs, ys, zs} = '0;
		repeat (16) @(posedge clk_in);
		#1;
		rstn_in = 1'b1;
		chk1("checksum_off", 1'b0, chk_off);
		rdchk("test_setup", 8'h0f, TS, 1'b0);
		for (int a = 16; a < 21; a++)
			rdchk("reset_word", a[7:0], 16'h0000, 1'b0);
		rdchk("unmapped", 8'h0e, 16'h0000, 1'b1);
		$display("test reset done");
		wreg(8'h0f, 16'hffff);
		chk1("checksum_off", 1'b1, chk_off);
		rdchk("test_setup", 8'h0f, TS | 16'h0007, 1'b0);
		wreg(8'h0f, 16'h0000);
		chk1("checksum_off", 1'b0, chk_off);
		$display("test setup done");
		for (int c = 1; c < 3; c++)
		begin
			n = 1 + int'(rnd() % 40);
			wreg(8'h0f, 16'(c));
			wreg(8'h10, 16'hffff);
			pulses(c == 1 ? n : n + 3, c == 1 ? n + 3 : n);
			rdchk("tally", 8'h10, n[15:0], 1'b0);
			wreg(8'h0f, 16'h0003);
			pulses(5, 5);
			rdchk("tally_held", 8'h10, n[15:0], 1'b0);
			wreg(8'h0f, 16'h0000);
			@(posedge clk_in);
			rdchk("tally_clear", 8'h10, 16'h0000, 1'b0);
		end
		$display("test counter done");
		r = rnd();
		@(posedge clk_in);
		#1;
		ang = r[12:0];
		mag = r[31:16];
		rval = 1'b1;
		@(posedge clk_in);
		#1;
		rval = 1'b0;
		ang = ~ang;
		mag = ~mag;
		wreg(8'h13, 16'hffff);
		wreg(8'h14, 16'h0000);
		rdchk("angle", 8'h13, {3'h0, r[12:0]}, 1'b0);
		rdchk("length", 8'h14, r[31:16], 1'b0);
		$display("test results done");
		for (int k = 0; k < 64; k++)
		begin
			r = rnd();
			gw = {k[1:0], 3'h7, r[10:0]};
			ow = {k[3:2], r[27:14]};
			pair = k[5:4];
			wreg(8'h11, gw);
			rdchk("gain", 8'h11, gw & 16'hc7ff, 1'b0);
			wreg(8'h12, ow);
			rdchk("offset", 8'h12, ow, 1'b0);
			r = rnd();
			@(posedge clk_in);
			#1;
			xs = r[15:0];
			ys = r[31:16];
			r = rnd();
			zs = r[15:0];
			sval = 1'b1;
			@(posedge clk_in);
			#1;
			sval = 1'b0;
			chk1("corr_valid", 1'b1, cval);
			chk16("x_corr", corr(xs, gw[15:14] == 2'h1, ow[14] && pair[0], 1'b0,
				gw[10:0], ow[13:7], ow[6:0]), xc);
			chk16("y_corr", corr(ys, gw[15:14] == 2'h2, ow[14] && pair == 2'h2,
				ow[15] && pair == 2'h1, gw[10:0], ow[13:7], ow[6:0]), yc);
			chk16("z_corr", corr(zs, gw[15:14] == 2'h3, 1'b0, ow[15] && pair[1],
				gw[10:0], ow[13:7], ow[6:0]), zc);
		end
		$display("test correction done");
		summarize();
	end
endmodule
